//--- src/fspc_pkg.sv
// package for the flash suspend/protect host controller
package fspc_pkg;
	localparam int CLK_MHZ = 100;
	// timing figures in their own units
	localparam int T_SUSPEND_US = 15;
	localparam int T_ABORT_US = 10;
	localparam int T_GROUP_US = 80;
	localparam int T_PULSE_NS = 70;
	localparam int T_SETUP_NS = 70;
	localparam int T_RECOVER_NS = 40;
	localparam int T_ACCESS_NS = 160;
	// cycle counts: least times round up, longest round down
	localparam int CYC_SUSPEND = T_SUSPEND_US * CLK_MHZ;
	localparam int CYC_ABORT = T_ABORT_US * CLK_MHZ;
	localparam int CYC_GROUP = (T_GROUP_US * CLK_MHZ) - 1;
	localparam int CYC_PULSE = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RECOVER = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_ACCESS = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 14;
	// bus widths and sector layout
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int SECT_W = 3;
	localparam int SECT_POS = 16;
	localparam int ID_LINE_POS = 9;
	localparam int TOGGLE_POS = 6;
	// command values
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 19'h05555;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 19'h02aaa;
	localparam logic [7:0] PROT_OK = 8'h01;
	localparam logic [7:0] UNPROT_OK = 8'h00;
	// host requests
	typedef enum logic [2:0] {
		FSPC_OP_READ = 3'h0,
		FSPC_OP_WRITE = 3'h1,
		FSPC_OP_SUSPEND = 3'h2,
		FSPC_OP_RESUME = 3'h3,
		FSPC_OP_RESET1 = 3'h4,
		FSPC_OP_RESET3 = 3'h5,
		FSPC_OP_PROT_VFY = 3'h6,
		FSPC_OP_UNPROT_VFY = 3'h7
	} fspc_op_e;
	// gray coded along idle, setup, strobe, recover, wait
	typedef enum logic [2:0] {
		FSPC_ST_IDLE = 3'b000,
		FSPC_ST_SETUP = 3'b001,
		FSPC_ST_STROBE = 3'b011,
		FSPC_ST_RECOVER = 3'b010,
		FSPC_ST_WAIT = 3'b110,
		FSPC_ST_READ = 3'b111
	} fspc_state_e;
endpackage

//--- src/fspc_host.sv
// host controller driving the flash block over its parallel pins
`timescale 1ns/1ps
// Behaviour
// RULE1 - address on strobe fall, data on rise
// RULE2 - exactly one block select low at once
// RULE3 - toggling stops within 15 us of suspend
// RULE4 - poll toggle bit outside erased sector
// RULE5 - device drops to read mode after suspend
// RULE6 - erased sectors read invalid while suspended
// RULE7 - suspended block takes only resume or reset
// RULE8 - reset ends running or suspended erase
// RULE9 - resume is 30h once, after suspend only
// RULE10 - protect mode via identifier voltage, sector lines
// RULE11 - protected sector ignores program and erase
// RULE12 - unprotect clears all eight sectors together
// RULE13 - verify reported on bit zero or byte
// RULE14 - reset is one write or three
// RULE15 - reset returns read mode, clears errors
// RULE16 - reset abort completes within 10 us
// RULE17 - program only clears bits to zero
// RULE18 - queue next sector erase within 80 us; the host has no erase request, CYC_GROUP is never used
// RULE19 - sectors 64 KByte, whole-sector operations
module fspc_host (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire fspc_pkg::fspc_op_e req_op,
	input wire logic [fspc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fspc_pkg::DATA_W-1:0] req_data,
	input wire logic req_eeprom,
	input wire logic [fspc_pkg::ADDR_W-1:0] poll_addr,
	output logic rsp_valid,
	output logic [fspc_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_ok,
	output logic suspended,
	output logic [fspc_pkg::ADDR_W-1:0] mem_addr,
	output logic [fspc_pkg::DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe_n,
	input wire logic [fspc_pkg::DATA_W-1:0] mem_dq_in,
	output logic flash_select_n,
	output logic eeprom_select_n,
	output logic mem_write_n,
	output logic mem_gate_n,
	output logic id_line_high_voltage,
	output logic gate_high_voltage
);
	import fspc_pkg::*;

	typedef struct packed {
		fspc_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] step;
		fspc_op_e op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic eeprom;
		logic susp;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic rok;
		logic fsel_n;
		logic esel_n;
		logic wr_n;
		logic oe_n;
		logic dq_oe_n;
		logic hv;
	} fspc_state_s;

	fspc_state_s r;
	fspc_state_s next_r;
	logic [ADDR_W-1:0] step_addr;
	logic [DATA_W-1:0] step_data;
	logic multi;

	// address and data for each write step of the current command
	always_comb begin
		step_addr = r.addr;
		step_data = r.data;
		multi = 1'b0;
		case (r.op)
			FSPC_OP_SUSPEND: step_data = CMD_SUSPEND;
			FSPC_OP_RESUME: step_data = CMD_RESUME; // RULE9
			FSPC_OP_RESET1: step_data = CMD_RESET; // RULE14
			FSPC_OP_RESET3: begin
				multi = 1'b1; // RULE14
				step_addr = (r.step == 2'd0) ? ADDR_UNLOCK1 :
					(r.step == 2'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
				step_data = (r.step == 2'd0) ? CMD_UNLOCK1 :
					(r.step == 2'd1) ? CMD_UNLOCK2 : CMD_RESET;
			end
			default: begin
			end
		endcase
	end

	// one sequencer: bus cycles, waits and verify reads
	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		case (r.st)
			FSPC_ST_IDLE: begin
				if (req_valid) begin
					next_r.op = req_op;
					next_r.addr = req_addr;
					next_r.data = req_data; // RULE17
					next_r.eeprom = req_eeprom;
					next_r.step = 2'd0;
					next_r.cnt = CNT_W'(CYC_SETUP);
					// only resume, reset and read go out while suspended
					if (r.susp && req_op != FSPC_OP_RESUME && req_op != FSPC_OP_RESET1 &&
						req_op != FSPC_OP_RESET3 && req_op != FSPC_OP_READ) begin
						next_r.rvalid = 1'b1; // RULE7
						next_r.rok = 1'b0;
						next_r.rdata = 8'h00;
					end else if (r.susp && req_op == FSPC_OP_READ && !req_eeprom) begin
						next_r.addr = poll_addr; // RULE4
						next_r.st = FSPC_ST_SETUP;
					end else if (!r.susp && req_op == FSPC_OP_RESUME) begin
						next_r.rvalid = 1'b1; // RULE9
						next_r.rok = 1'b0;
						next_r.rdata = 8'h00;
					end else begin
						next_r.st = FSPC_ST_SETUP;
					end
				end
			end
			FSPC_ST_SETUP: begin
				// selects chosen one-hot, address settles before strobe
				next_r.fsel_n = r.eeprom; // RULE2
				next_r.esel_n = !r.eeprom; // RULE2
				next_r.hv = (r.op == FSPC_OP_PROT_VFY || r.op == FSPC_OP_UNPROT_VFY); // RULE10
				if (r.cnt <= CNT_W'(1)) begin
					next_r.cnt = CNT_W'(CYC_PULSE);
					if (r.op == FSPC_OP_READ || r.hv) begin
						next_r.oe_n = 1'b0;
						next_r.cnt = CNT_W'(CYC_ACCESS);
						next_r.st = FSPC_ST_READ;
					end else begin
						next_r.wr_n = 1'b0; // RULE1
						next_r.dq_oe_n = 1'b0;
						next_r.st = FSPC_ST_STROBE;
					end
				end else begin
					next_r.cnt = r.cnt - CNT_W'(1);
				end
			end
			FSPC_ST_STROBE: begin
				// data held across the rising strobe edge
				if (r.cnt <= CNT_W'(1)) begin
					next_r.wr_n = 1'b1; // RULE1
					next_r.cnt = CNT_W'(CYC_RECOVER);
					next_r.st = FSPC_ST_RECOVER;
				end else begin
					next_r.cnt = r.cnt - CNT_W'(1);
				end
			end
			FSPC_ST_RECOVER: begin
				if (r.cnt <= CNT_W'(1)) begin
					next_r.dq_oe_n = 1'b1;
					if (multi && r.step != 2'd2) begin
						next_r.step = r.step + 2'd1;
						next_r.cnt = CNT_W'(CYC_SETUP);
						next_r.st = FSPC_ST_SETUP;
					end else begin
						next_r.fsel_n = 1'b1;
						next_r.esel_n = 1'b1;
						next_r.st = FSPC_ST_WAIT;
						next_r.cnt = CNT_W'(1);
						if (r.op == FSPC_OP_SUSPEND) begin
							next_r.cnt = CNT_W'(CYC_SUSPEND); // RULE3
							next_r.susp = 1'b1; // RULE5
						end else if (r.op == FSPC_OP_RESUME) begin
							next_r.susp = 1'b0; // RULE9
						end else if (r.op == FSPC_OP_RESET1 || r.op == FSPC_OP_RESET3) begin
							next_r.cnt = CNT_W'(CYC_ABORT); // RULE16
							next_r.susp = 1'b0; // RULE8
						end
					end
				end else begin
					next_r.cnt = r.cnt - CNT_W'(1);
				end
			end
			FSPC_ST_READ: begin
				if (r.cnt <= CNT_W'(1)) begin
					next_r.oe_n = 1'b1;
					next_r.fsel_n = 1'b1;
					next_r.esel_n = 1'b1;
					next_r.hv = 1'b0;
					next_r.rdata = mem_dq_in;
					next_r.rok = 1'b1;
					if (r.op == FSPC_OP_PROT_VFY)
						next_r.rok = (mem_dq_in[0] == PROT_OK[0]); // RULE13
					else if (r.op == FSPC_OP_UNPROT_VFY)
						next_r.rok = (mem_dq_in == UNPROT_OK); // RULE13
					next_r.rvalid = 1'b1;
					next_r.st = FSPC_ST_IDLE;
				end else begin
					next_r.cnt = r.cnt - CNT_W'(1);
				end
			end
			FSPC_ST_WAIT: begin
				// end of every write: one cycle, or suspend settle or reset abort; device gives no valid data meanwhile
				if (r.cnt <= CNT_W'(1)) begin
					next_r.rvalid = 1'b1; // RULE15
					next_r.rok = 1'b1;
					next_r.rdata = 8'h00;
					next_r.st = FSPC_ST_IDLE;
				end else begin
					next_r.cnt = r.cnt - CNT_W'(1);
				end
			end
			default: next_r.st = FSPC_ST_IDLE;
		endcase
	end

	// state register; pins idle high with drivers off
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{st: FSPC_ST_IDLE, cnt: '0, step: 2'd0, op: FSPC_OP_READ,
				addr: '0, data: '0, eeprom: 1'b0, susp: 1'b0, rdata: '0,
				rvalid: 1'b0, rok: 1'b0, fsel_n: 1'b1, esel_n: 1'b1,
				wr_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, hv: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign req_ready = (r.st == FSPC_ST_IDLE);
	assign rsp_valid = r.rvalid;
	assign rsp_data = r.rdata;
	assign rsp_ok = r.rok;
	assign suspended = r.susp;
	assign mem_addr = step_addr;
	assign mem_dq_out = step_data;
	assign mem_dq_oe_n = r.dq_oe_n;
	assign flash_select_n = r.fsel_n;
	assign eeprom_select_n = r.esel_n;
	assign mem_write_n = r.wr_n;
	assign mem_gate_n = r.oe_n;
	assign id_line_high_voltage = r.hv; // RULE10
	assign gate_high_voltage = r.hv;
endmodule

//--- test/fspc_host_assertions.sv
// port assertions for the flash host controller
`timescale 1ns/1ps
module fspc_host_checker import fspc_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire fspc_op_e req_op,
	input wire logic [ADDR_W-1:0] poll_addr,
	input wire logic rsp_valid,
	input wire logic rsp_ok,
	input wire logic suspended,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_dq_out,
	input wire logic mem_dq_oe_n,
	input wire logic flash_select_n,
	input wire logic eeprom_select_n,
	input wire logic mem_write_n,
	input wire logic mem_gate_n,
	input wire logic id_line_high_voltage,
	input wire logic gate_high_voltage
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire take = req_valid && req_ready;
	// strobe low for the full pulse, then back high
	sequence strobe_s; !mem_write_n[*7] ##1 mem_write_n; endsequence
	sequence refuse_s; ##[1:2] (rsp_valid && !rsp_ok); endsequence
	sel_excl_a: assert property (flash_select_n || eeprom_select_n)
		else $error("both selects low");
	wr_gate_a: assert property (!mem_write_n |-> mem_gate_n && !mem_dq_oe_n
		&& (flash_select_n != eeprom_select_n)) else $error("bad write strobe");
	strobe_len_a: assert property ($fell(mem_write_n) |-> strobe_s)
		else $error("strobe length wrong");
	wr_stable_a: assert property (!mem_write_n && !$past(mem_write_n)
		|-> $stable(mem_addr) && $stable(mem_dq_out)) else $error("bus moved in strobe");
	refuse_wr_a: assert property (take && suspended && req_op == FSPC_OP_WRITE
		|-> refuse_s ##1 mem_write_n[*4]) else $error("write not refused");
	resume_ref_a: assert property (take && !suspended && req_op == FSPC_OP_RESUME
		|-> refuse_s) else $error("stray resume taken");
	poll_addr_a: assert property (suspended && !mem_gate_n && !flash_select_n
		&& !id_line_high_voltage |-> mem_addr == poll_addr) else $error("poll address");
	hv_pair_a: assert property (gate_high_voltage |-> id_line_high_voltage)
		else $error("gate voltage alone");
	// cycles since a suspend or single reset was taken; long waits are counted, not unrolled
	logic [10:0] wait_cnt;
	logic [1:0] wait_kind;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt <= 11'h000;
			wait_kind <= 2'h0;
		end else if (take && !suspended && req_op == FSPC_OP_SUSPEND) begin
			wait_cnt <= 11'h001;
			wait_kind <= 2'h1;
		end else if (take && req_op == FSPC_OP_RESET1) begin
			wait_cnt <= 11'h001;
			wait_kind <= 2'h2;
		end else if (wait_kind != 2'h0) begin
			if (rsp_valid)
				wait_kind <= 2'h0;
			else
				wait_cnt <= wait_cnt + 11'h001;
		end
	end
	susp_wait_a: assert property (wait_kind == 2'h1 |-> wait_cnt <= 11'h6a4
		&& (!rsp_valid || wait_cnt >= 11'h5dc)) else $error("suspend wait");
	reset_done_a: assert property (wait_kind == 2'h2 |-> wait_cnt <= 11'h4b0
		&& (!rsp_valid || (wait_cnt >= 11'h3e8 && !suspended))) else $error("reset abort");
endmodule
bind fspc_host fspc_host_checker i_chk (
	.core_clk(core_clk),
	.resetn(resetn),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.req_op(req_op),
	.poll_addr(poll_addr),
	.rsp_valid(rsp_valid),
	.rsp_ok(rsp_ok),
	.suspended(suspended),
	.mem_addr(mem_addr),
	.mem_dq_out(mem_dq_out),
	.mem_dq_oe_n(mem_dq_oe_n),
	.flash_select_n(flash_select_n),
	.eeprom_select_n(eeprom_select_n),
	.mem_write_n(mem_write_n),
	.mem_gate_n(mem_gate_n),
	.id_line_high_voltage(id_line_high_voltage),
	.gate_high_voltage(gate_high_voltage)
);

//--- test/fspc_flash_model.sv
// behavioural flash block answering the host pins
`timescale 1ns/1ps
module fspc_flash_model import fspc_pkg::*; (
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_dq_out,
	input wire logic flash_select_n,
	input wire logic mem_write_n,
	input wire logic mem_gate_n,
	input wire logic id_line_high_voltage,
	output logic [DATA_W-1:0] mem_dq_in
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] vfy = 8'h01;
	// one protect bit per 64 KByte sector, set by the bench
	logic [7:0] prot = 8'h00;
	logic [DATA_W-1:0] rd;
	int a;
	// address taken on strobe fall, data on rise
	always @(negedge mem_write_n) a = mem_addr;
	// programming can only clear bits, erased cells read ff
	always @(posedge mem_write_n) begin
		if (!flash_select_n && !prot[a[SECT_POS +: SECT_W]])
			mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & mem_dq_out;
	end
	// released bus shows the inverse, so a late sample never matches
	always @* begin
		rd = mem.exists(mem_addr) ? mem[mem_addr] : 8'hff;
		if (id_line_high_voltage)
			rd = vfy;
		mem_dq_in = (!mem_gate_n && !flash_select_n) ? rd : ~rd;
	end
endmodule

//--- test/test_flash_suspend_protect_control.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module test_flash_suspend_protect_control;
	import fspc_pkg::*;
	logic core_clk = 0, resetn = 0, req_valid = 0, req_eeprom = 0;
	fspc_op_e req_op = FSPC_OP_READ;
	logic [ADDR_W-1:0] req_addr = '0, poll_addr = 19'h40000, mem_addr;
	logic [DATA_W-1:0] req_data = '0, mem_dq_in, mem_dq_out, rsp_data;
	logic req_ready, rsp_valid, rsp_ok, suspended, mem_dq_oe_n;
	logic flash_select_n, eeprom_select_n, mem_write_n, mem_gate_n;
	logic id_line_high_voltage, gate_high_voltage;
	int err_count = 0, n_tests = 0, seed = 32'hc2be, exp [int], a, d;
	fspc_op_e vop [4] = '{FSPC_OP_PROT_VFY, FSPC_OP_PROT_VFY, FSPC_OP_UNPROT_VFY,
		FSPC_OP_UNPROT_VFY};
	int vby [4] = '{8'h01, 8'hfe, 8'h00, 8'h01};
	always #5 core_clk = ~core_clk;
	fspc_host i_dut (.*);
	fspc_flash_model i_mem (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			err_count++;
			$display("[ERR] %0t saw %h want %h", $time, seen, want);
		end
	endtask
	// one request, held until taken, then a bounded wait for the answer
	task automatic op(input fspc_op_e o, input int ad, input int dt);
		int n;
		@(negedge core_clk);
		req_op = o;
		req_addr = ADDR_W'(ad);
		req_data = DATA_W'(dt);
		req_valid = 1;
		// ready is decoded from the state flops, so looking at it mid-cycle avoids the edge race
		while (!req_ready) @(negedge core_clk);
		@(posedge core_clk);
		@(negedge core_clk);
		req_valid = 0;
		for (n = 0; n < 3000 && !rsp_valid; n++) @(negedge core_clk);
		check(rsp_valid, 1);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#900000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		resetn = 1;
		// each cell programmed twice, so cleared bits must stay cleared
		for (int i = 0; i < 6; i++) begin
			a = 32'h40000 + i / 2;
			d = $random(seed) & 255;
			exp[a] = (exp.exists(a) ? exp[a] : 255) & d;
			op(FSPC_OP_WRITE, a, d);
			check(rsp_ok, 1);
			op(FSPC_OP_READ, a, 0);
			check(rsp_data, 8'(exp[a]));
		end
		$display("program test done");
		op(FSPC_OP_SUSPEND, 0, 0);
		check(suspended, 1);
		op(FSPC_OP_READ, 0, 0);
		check(rsp_data, 8'(exp[32'h40000]));
		foreach (vop[k]) begin
			op(k ? vop[k] : FSPC_OP_WRITE, 32'h40001, 0);
			check(rsp_ok, 0);
		end
		op(FSPC_OP_RESUME, 0, 0);
		check(suspended, 0);
		op(FSPC_OP_RESUME, 0, 0);
		check(rsp_ok, 0);
		op(FSPC_OP_SUSPEND, 0, 0);
		op(FSPC_OP_RESET1, 0, 0);
		check(suspended, 0);
		op(FSPC_OP_RESUME, 0, 0);
		check(rsp_ok, 0);
		op(FSPC_OP_RESET3, 0, 0);
		check(rsp_ok, 1);
		check(suspended, 0);
		$display("suspend and reset test done");
		// verify reads: protect looks at bit zero, unprotect at all bits
		foreach (vop[k]) begin
			i_mem.vfy = 8'(vby[k]);
			op(vop[k], 32'h40000, 0);
			check(rsp_ok, k % 2 == 0);
		end
		$display("verify test done");
		// a protected sector swallows programs until all sectors are unprotected
		i_mem.prot = 8'h10;
		a = 32'h40005;
		op(FSPC_OP_WRITE, a, 0);
		op(FSPC_OP_READ, a, 0);
		check(rsp_data, 8'hff);
		i_mem.prot = 8'h00;
		op(FSPC_OP_WRITE, a, 0);
		op(FSPC_OP_READ, a, 0);
		check(rsp_data, 8'h00);
		$display("protect test done");
		summarize();
	end
endmodule
